/* File: shared/t2rc_pkg.sv */
// holds register indices, field positions and reset values of the reload/compare timer
// assumes APB byte addresses equal four times each register index
package t2rc_pkg;

	// ********************************************
	// register indices (byte address = index * 4)
	// ********************************************
	localparam logic [7:0] T2RC_IDX_STATUS = 8'hC4;
	localparam logic [7:0] T2RC_IDX_MASK = 8'hC5;
	localparam logic [7:0] T2RC_IDX_CTRL = 8'hC8;
	localparam logic [7:0] T2RC_IDX_RC_LOW = 8'hCA;
	localparam logic [7:0] T2RC_IDX_RC_HIGH = 8'hCB;
	localparam logic [7:0] T2RC_IDX_CNT_LOW = 8'hCC;
	localparam logic [7:0] T2RC_IDX_CNT_HIGH = 8'hCD;

	// ********************************************
	// control register fields
	// ********************************************
	localparam int T2RC_CTRL_MODE = 0;
	localparam int T2RC_CTRL_RUN = 1;
	localparam int T2RC_CTRL_AUTO_CLEAR = 2;
	localparam int T2RC_CTRL_RELOAD_EN = 3;
	localparam int T2RC_CTRL_TSEL_LSB = 4;

	// ********************************************
	// status and mask fields
	// ********************************************
	localparam int T2RC_ST_OVERFLOW = 0;
	localparam int T2RC_ST_MATCH = 1;
	localparam int T2RC_ST_RELOAD = 2;
	localparam int T2RC_ST_WIDTH = 3;

	// ********************************************
	// reset values and encodings
	// ********************************************
	localparam logic [7:0] T2RC_RST_BYTE = 8'h00;
	localparam logic [15:0] T2RC_CNT_MAX = 16'hFFFF;
	localparam logic [1:0] T2RC_TRIG_OVERFLOW = 2'h0;
	localparam logic [1:0] T2RC_TRIG_CAP0 = 2'h1;
	localparam logic [1:0] T2RC_TRIG_CAP1 = 2'h2;
	localparam logic [1:0] T2RC_TRIG_CAP2 = 2'h3;

endpackage

/* File: verilog/t2rc_timer.sv */
// 16-bit timer with auto-reload and compare modes behind an APB slave
// assumes capture events arrive as one-cycle pulses synchronous to SYS_CLK
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module t2rc_timer import t2rc_pkg::*; (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [2:0] CAP_EVENT,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	output logic IRQ
);

	// ********************************************
	// state
	// ********************************************
	logic [15:0] cnt;
	logic [7:0] rc_lo;
	logic [7:0] rc_hi;
	logic mode;
	logic run;
	logic clr_en;
	logic ld_en;
	logic [1:0] tsel;
	logic [T2RC_ST_WIDTH-1:0] stat;
	logic [T2RC_ST_WIDTH-1:0] mask;

	logic [15:0] next_cnt;
	logic [7:0] next_rc_lo;
	logic [7:0] next_rc_hi;
	logic next_mode;
	logic next_run;
	logic next_clr_en;
	logic next_ld_en;
	logic [1:0] next_tsel;
	logic [T2RC_ST_WIDTH-1:0] next_stat;
	logic [T2RC_ST_WIDTH-1:0] next_mask;
	logic next_pready;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic next_irq;

	// ********************************************
	// bus decode
	// ********************************************
	logic [7:0] idx;
	logic mapped;
	logic setup;
	logic wr_en;
	logic [7:0] ctrl_word;
	logic [31:0] rd_word;

	assign idx = PADDR[9:2];
	assign setup = PSEL && !PENABLE;
	// writes land only at the accepted access edge, never on an errored one
	assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
	assign ctrl_word = {2'h0, tsel, ld_en, clr_en, run, mode};

	always_comb begin
		mapped = 1'b0;
		rd_word = 32'h0000_0000;
		if (PADDR[11:10] == 2'h0 && PADDR[1:0] == 2'h0) begin
			mapped = 1'b1;
			case (idx)
				T2RC_IDX_STATUS: rd_word = {29'h0, stat};
				T2RC_IDX_MASK: rd_word = {29'h0, mask};
				T2RC_IDX_CTRL: rd_word = {24'h0, ctrl_word};
				T2RC_IDX_RC_LOW: rd_word = {24'h0, rc_lo};
				T2RC_IDX_RC_HIGH: rd_word = {24'h0, rc_hi};
				T2RC_IDX_CNT_LOW: rd_word = {24'h0, cnt[7:0]};
				T2RC_IDX_CNT_HIGH: rd_word = {24'h0, cnt[15:8]};
				default: mapped = 1'b0;
			endcase
		end
	end

	// ********************************************
	// bus slave and configuration registers
	// ********************************************
	always_comb begin
		// one access cycle: ready is raised in the cycle after setup
		next_pready = setup;
		next_prdata = (setup && !PWRITE) ? rd_word : 32'h0000_0000;
		next_pslverr = setup && !mapped;
		next_rc_lo = rc_lo;
		next_rc_hi = rc_hi;
		next_mode = mode;
		next_run = run;
		next_clr_en = clr_en;
		next_ld_en = ld_en;
		next_tsel = tsel;
		next_mask = mask;
		if (wr_en) begin
			case (idx)
				T2RC_IDX_RC_LOW: next_rc_lo = PWDATA[7:0];
				T2RC_IDX_RC_HIGH: next_rc_hi = PWDATA[7:0];
				T2RC_IDX_MASK: next_mask = PWDATA[T2RC_ST_WIDTH-1:0];
				T2RC_IDX_CTRL: begin
					next_mode = PWDATA[T2RC_CTRL_MODE];
					next_run = PWDATA[T2RC_CTRL_RUN];
					next_clr_en = PWDATA[T2RC_CTRL_AUTO_CLEAR];
					next_ld_en = PWDATA[T2RC_CTRL_RELOAD_EN];
					next_tsel = PWDATA[T2RC_CTRL_TSEL_LSB+1:T2RC_CTRL_TSEL_LSB];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			rc_lo <= T2RC_RST_BYTE;
			rc_hi <= T2RC_RST_BYTE;
			mode <= 1'b0;
			run <= 1'b0;
			clr_en <= 1'b0;
			ld_en <= 1'b0;
			tsel <= T2RC_TRIG_OVERFLOW;
			mask <= 3'h0;
		end else begin
			PREADY <= next_pready;
			PRDATA <= next_prdata;
			PSLVERR <= next_pslverr;
			rc_lo <= next_rc_lo;
			rc_hi <= next_rc_hi;
			mode <= next_mode;
			run <= next_run;
			clr_en <= next_clr_en;
			ld_en <= next_ld_en;
			tsel <= next_tsel;
			mask <= next_mask;
		end
	end

	// ********************************************
	// counter, events and interrupt
	// ********************************************
	logic [15:0] cmp_val;
	logic ovf_ev;
	logic match_ev;
	logic trig;
	logic reload_ev;
	logic cnt_wr;
	logic [T2RC_ST_WIDTH-1:0] set_bits;
	logic [T2RC_ST_WIDTH-1:0] clr_bits;

	assign cmp_val = {rc_hi, rc_lo};
	assign cnt_wr = wr_en && (idx == T2RC_IDX_CNT_LOW || idx == T2RC_IDX_CNT_HIGH);

	always_comb begin
		ovf_ev = run && (cnt == T2RC_CNT_MAX);
		match_ev = run && mode && (cnt == cmp_val);
		case (tsel)
			T2RC_TRIG_OVERFLOW: trig = ovf_ev;
			T2RC_TRIG_CAP0: trig = run && CAP_EVENT[0];
			T2RC_TRIG_CAP1: trig = run && CAP_EVENT[1];
			T2RC_TRIG_CAP2: trig = run && CAP_EVENT[2];
			default: trig = 1'b0;
		endcase
		// reloading belongs to auto-reload mode only
		reload_ev = !mode && ld_en && trig;
		next_cnt = cnt;
		if (reload_ev) begin
			next_cnt = cmp_val;
		end else if (match_ev && clr_en) begin
			next_cnt = 16'h0000;
		end else if (run) begin
			next_cnt = 16'(cnt + 16'h0001);
		end
		// software byte writes beat the hardware update of that byte
		if (wr_en && idx == T2RC_IDX_CNT_LOW) begin
			next_cnt[7:0] = PWDATA[7:0];
		end
		if (wr_en && idx == T2RC_IDX_CNT_HIGH) begin
			next_cnt[15:8] = PWDATA[7:0];
		end
		set_bits = 3'h0;
		set_bits[T2RC_ST_OVERFLOW] = ovf_ev || match_ev;
		set_bits[T2RC_ST_MATCH] = match_ev;
		set_bits[T2RC_ST_RELOAD] = reload_ev;
		clr_bits = (wr_en && idx == T2RC_IDX_STATUS) ? PWDATA[T2RC_ST_WIDTH-1:0] : 3'h0;
		// an event in the clearing cycle survives
		next_stat = (stat & ~clr_bits) | set_bits;
		next_irq = |(next_stat & next_mask);
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt <= {T2RC_RST_BYTE, T2RC_RST_BYTE};
			stat <= 3'h0;
			IRQ <= 1'b0;
		end else begin
			cnt <= next_cnt;
			stat <= next_stat;
			IRQ <= next_irq;
		end
	end

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	a_overflow_reload: assert property (
		run && !mode && ld_en && tsel == T2RC_TRIG_OVERFLOW && cnt == 16'hFFFF && !cnt_wr
		|=> cnt == $past(cmp_val))
		else $error("overflow did not reload counter");

	a_capture_reload: assert property (
		run && !mode && ld_en && tsel == T2RC_TRIG_CAP1 && CAP_EVENT[1] && !cnt_wr
		|=> cnt == $past(cmp_val) && stat[T2RC_ST_RELOAD])
		else $error("capture 1 did not reload counter");

	a_capture_ignored: assert property (
		run && !mode && tsel == T2RC_TRIG_CAP2 && !CAP_EVENT[2] && cnt != 16'hFFFF
		&& !cnt_wr |=> cnt == 16'($past(cnt) + 16'h0001))
		else $error("counter reloaded without its capture event");

	a_match_flags: assert property (
		run && mode && cnt == {rc_hi, rc_lo}
		|=> stat[T2RC_ST_MATCH] && stat[T2RC_ST_OVERFLOW])
		else $error("compare match not flagged");

	a_low_readback: assert property (
		setup && !PWRITE && mapped && idx == T2RC_IDX_CNT_LOW
		|=> PREADY && PRDATA == {24'h0, $past(cnt[7:0])})
		else $error("low counter byte read wrong");

	a_high_readback: assert property (
		setup && !PWRITE && mapped && idx == T2RC_IDX_CNT_HIGH
		|=> PREADY && PRDATA == {24'h0, $past(cnt[15:8])})
		else $error("high counter byte read wrong");

	a_flag_sticky: assert property (
		stat[T2RC_ST_OVERFLOW] && !(wr_en && idx == T2RC_IDX_STATUS)
		|=> stat[T2RC_ST_OVERFLOW])
		else $error("overflow flag dropped without software");

	a_flag_set: assert property (
		run && cnt == 16'hFFFF |=> stat[T2RC_ST_OVERFLOW])
		else $error("overflow flag not set on overflow");

	a_compare_noreload: assert property (
		run && mode && ld_en && cnt == 16'hFFFF && cmp_val != 16'hFFFF && !cnt_wr
		|=> cnt == 16'h0000)
		else $error("compare mode must not reload");

	a_reload_off: assert property (
		run && !mode && !ld_en && cnt == 16'hFFFF && !cnt_wr |=> cnt == 16'h0000)
		else $error("reload happened while disabled");

	a_auto_clear: assert property (
		run && mode && clr_en && cnt == cmp_val && !cnt_wr |=> cnt == 16'h0000)
		else $error("counter not cleared after match");

	a_match_continue: assert property (
		run && mode && !clr_en && cnt == cmp_val && cnt != 16'hFFFF && !cnt_wr
		|=> cnt == 16'($past(cnt) + 16'h0001))
		else $error("counter did not continue after match");

	a_irq_level: assert property (
		##1 IRQ == |(stat & mask))
		else $error("interrupt output disagrees with status");

	// ********************************************
	// bus and register assertions
	// ********************************************
	a_access_answer: assert property (
		setup |=> PREADY)
		else $error("no ready in the access cycle");

	a_ready_single: assert property (
		PREADY |=> !PREADY)
		else $error("ready stood longer than one cycle");

	a_write_data_zero: assert property (
		setup && PWRITE |=> PRDATA == 32'h0000_0000)
		else $error("read data not zero on a write");

	a_low_write: assert property (
		wr_en && idx == T2RC_IDX_CNT_LOW |=> cnt[7:0] == $past(PWDATA[7:0]))
		else $error("low counter byte write lost");

	a_high_write: assert property (
		wr_en && idx == T2RC_IDX_CNT_HIGH |=> cnt[15:8] == $past(PWDATA[7:0]))
		else $error("high counter byte write lost");

	a_cmp_low_write: assert property (
		wr_en && idx == T2RC_IDX_RC_LOW |=> rc_lo == $past(PWDATA[7:0]))
		else $error("reload/compare low byte write lost");

	a_cmp_high_write: assert property (
		wr_en && idx == T2RC_IDX_RC_HIGH |=> rc_hi == $past(PWDATA[7:0]))
		else $error("reload/compare high byte write lost");

	// a stopped timer keeps its count for software to read back
	a_halt_hold: assert property (
		!run && !cnt_wr |=> cnt == $past(cnt))
		else $error("stopped counter moved");

	a_capture0_reload: assert property (
		run && !mode && ld_en && tsel == T2RC_TRIG_CAP0 && CAP_EVENT[0] && !cnt_wr
		|=> cnt == $past(cmp_val))
		else $error("capture 0 did not reload counter");

	a_capture2_reload: assert property (
		run && !mode && ld_en && tsel == T2RC_TRIG_CAP2 && CAP_EVENT[2] && !cnt_wr
		|=> cnt == $past(cmp_val))
		else $error("capture 2 did not reload counter");

	a_overflow_reload_flag: assert property (
		run && !mode && ld_en && tsel == T2RC_TRIG_OVERFLOW && cnt == T2RC_CNT_MAX
		|=> stat[T2RC_ST_RELOAD])
		else $error("overflow reload not flagged");

	a_count_on: assert property (
		run && !mode && !ld_en && cnt != T2RC_CNT_MAX && !cnt_wr
		|=> cnt == 16'($past(cnt) + 16'h0001))
		else $error("counter did not step with reload off");

	a_no_compare_reload: assert property (
		mode && !stat[T2RC_ST_RELOAD] |=> !stat[T2RC_ST_RELOAD])
		else $error("reload flagged in compare mode");

	a_no_auto_match: assert property (
		!mode && !stat[T2RC_ST_MATCH] |=> !stat[T2RC_ST_MATCH])
		else $error("match flagged in auto-reload mode");

	// the flag rises only for overflow or match, and a written one clears it
	a_flag_quiet: assert property (
		!stat[T2RC_ST_OVERFLOW] && !(run && cnt == T2RC_CNT_MAX)
		&& !(run && mode && cnt == cmp_val) |=> !stat[T2RC_ST_OVERFLOW])
		else $error("overflow flag set without an event");

	a_flag_clear: assert property (
		wr_en && idx == T2RC_IDX_STATUS && PWDATA[T2RC_ST_OVERFLOW]
		&& !(run && cnt == T2RC_CNT_MAX) && !(run && mode && cnt == cmp_val)
		|=> !stat[T2RC_ST_OVERFLOW])
		else $error("overflow flag survived its clear");

endmodule

/* File: dv/t2rc_cap_src.sv */
// partner model: the input-capture channels feeding the timer
// assumes fire and chan change just after a rising edge of clk
`timescale 1ns/100ps
module t2rc_cap_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic [1:0] chan,
	output logic [2:0] cap_event
);
	// *****************
	// event pulse
	// *****************
	// one cycle only: a longer pulse would count as repeated events
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_event <= 3'h0;
		end else begin
			cap_event <= fire ? 3'h1 << chan : 3'h0;
		end
	end
endmodule

/* File: dv/timer2_reload_compare_test.sv */
// self-checking bench of the reload/compare timer over APB
// assumes the t2rc_pkg register map and one-cycle capture pulses
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module timer2_reload_compare_test;
	import t2rc_pkg::*;
	logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic fire = 1'b0, pready, pslverr, irq;
	logic [1:0] chan = 2'h0, sel;
	logic [2:0] cap;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h483B;
	logic [32:0] qe[$], qm[$], exp_v, msk_v;
	logic [7:0] hi;
	logic [7:0] regs[7] = '{T2RC_IDX_STATUS, T2RC_IDX_MASK, T2RC_IDX_CTRL, T2RC_IDX_RC_LOW,
		T2RC_IDX_RC_HIGH, T2RC_IDX_CNT_LOW, T2RC_IDX_CNT_HIGH};
	int bad_count = 0, check_count = 0, cycles = 0;

	t2rc_timer DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .CAP_EVENT(cap),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq));
	t2rc_cap_src src (.clk(sys_clk), .rst_n(reset_n), .fire(fire), .chan(chan),
		.cap_event(cap));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// *****************
	// helpers
	// *****************
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task test_done;
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		qe.push_back(e);
		qm.push_back(m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task rd(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
		xfer(1'b0, idx, rnd, {25'h0, e}, {1'b1, 24'hFFFFFF, m});
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, {rnd[31:8], d}, 33'h0, 33'h1_0000_0000);
	endtask

	task pulse(input logic [1:0] c);
		fire <= 1'b1;
		chan <= c;
		@(posedge sys_clk);
		fire <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// *****************
	// checking
	// *****************
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			exp_v = qe.pop_front();
			msk_v = qm.pop_front();
			`CHK({pslverr, prdata} & msk_v, exp_v)
		end
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			test_done;
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 7; i++) rd(regs[i], 8'h00, 8'hFF);
		xfer(1'b0, 8'h10, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		for (int i = 3; i < 7; i++) begin
			rnd = xs(rnd);
			wr(regs[i], rnd[7:0]);
			rd(regs[i], rnd[7:0], 8'hFF);
		end
		// overflow with reload enabled, then disabled
		for (int i = 0; i < 2; i++) begin
			wr(T2RC_IDX_RC_LOW, 8'h00);
			wr(T2RC_IDX_RC_HIGH, 8'h12);
			wr(T2RC_IDX_CNT_LOW, 8'hF0);
			wr(T2RC_IDX_CNT_HIGH, 8'hFF);
			wr(T2RC_IDX_CTRL, i ? 8'h02 : 8'h0A);
			repeat (40) @(posedge sys_clk);
			rd(T2RC_IDX_CNT_HIGH, i ? 8'h00 : 8'h12, 8'hFF);
			wr(T2RC_IDX_CTRL, 8'h00);
			rd(T2RC_IDX_STATUS, 8'h01, 8'h01);
			wr(T2RC_IDX_STATUS, 8'h07);
			rd(T2RC_IDX_STATUS, 8'h00, 8'hFF);
		end
		// capture triggers: a foreign channel first must not reload
		for (int s = 1; s < 4; s++) begin
			sel = s[1:0];
			rnd = xs(rnd);
			hi = rnd[7:0] | 8'h01;
			wr(T2RC_IDX_RC_HIGH, hi);
			wr(T2RC_IDX_CNT_LOW, 8'h00);
			wr(T2RC_IDX_CNT_HIGH, 8'h00);
			wr(T2RC_IDX_CTRL, {2'h0, sel, 4'hA});
			pulse(sel == 2'h3 ? 2'h0 : sel);
			rd(T2RC_IDX_CNT_HIGH, 8'h00, 8'hFF);
			pulse(sel - 2'h1);
			rd(T2RC_IDX_CNT_HIGH, hi, 8'hFF);
			wr(T2RC_IDX_CTRL, 8'h00);
		end
		// compare with auto-clear; a swapped byte order would never match here
		wr(T2RC_IDX_STATUS, 8'h07);
		wr(T2RC_IDX_RC_LOW, 8'h30);
		wr(T2RC_IDX_RC_HIGH, 8'h00);
		wr(T2RC_IDX_CNT_LOW, 8'h00);
		wr(T2RC_IDX_CNT_HIGH, 8'h00);
		wr(T2RC_IDX_CTRL, 8'h07);
		repeat (300) @(posedge sys_clk);
		rd(T2RC_IDX_CNT_HIGH, 8'h00, 8'hFF);
		rd(T2RC_IDX_STATUS, 8'h03, 8'h03);
		// compare without auto-clear, reload on: overflow wraps, match counts on
		wr(T2RC_IDX_CTRL, 8'h00);
		wr(T2RC_IDX_STATUS, 8'h07);
		wr(T2RC_IDX_RC_LOW, 8'h80);
		wr(T2RC_IDX_RC_HIGH, 8'h01);
		wr(T2RC_IDX_CNT_LOW, 8'hF0);
		wr(T2RC_IDX_CNT_HIGH, 8'hFF);
		wr(T2RC_IDX_CTRL, 8'h0B);
		repeat (500) @(posedge sys_clk);
		rd(T2RC_IDX_CNT_HIGH, 8'h01, 8'hFF);
		rd(T2RC_IDX_STATUS, 8'h03, 8'h07);
		wr(T2RC_IDX_CTRL, 8'h00);
		wr(T2RC_IDX_MASK, 8'h02);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b1)
		wr(T2RC_IDX_MASK, 8'h00);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		wr(T2RC_IDX_MASK, 8'h02);
		wr(T2RC_IDX_STATUS, 8'h07);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		// mid-run reset: everything written so far returns to zero
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 7; i++) rd(regs[i], 8'h00, 8'hFF);
		test_done;
	end
endmodule
